// ==== verif/pcw_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcw_host_model (
    // Clock and pin
    input  wire logic CLK,
    output logic      PIN
);
    initial PIN = 1'b1;
    task burst(input int n);
        repeat (n) begin
            @(negedge CLK) PIN <= 1'b0;
            @(negedge CLK) PIN <= 1'b1;
        end
        // Pause past latch timeout plus pipeline slack
        repeat (32) @(negedge CLK);
    endtask : burst
    // Leaves the pin low; the next burst's first edge wakes the device
    task hold_low(input int n);
        @(negedge CLK) PIN <= 1'b0;
        repeat (n) @(negedge CLK);
    endtask : hold_low
endmodule : pcw_host_model
`default_nettype wire

// ==== verif/pcw_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcw_props
    import pcw_pkg::*;
#(
    parameter int SHUTDOWN_COUNT = 50
) (
    // Watched ports
    input wire logic          CLK,
    input wire logic          RST,
    input wire logic          CTRL_PIN,
    input wire logic          OVER_TEMP,
    input wire logic [3:0]    MAIN_LEVEL,
    input wire logic [3:0]    SUB_LEVEL,
    input wire logic [3:0]    LOW_CURRENT_LEVEL,
    input wire scale_sel_type SCALE_SEL,
    input wire logic          SHUTDOWN,
    input wire logic          BACKLIGHT_PUMP_EN,
    input wire logic          FLASH_PUMP_EN
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    // Saturates so a parked pin cannot wrap it
    int low_cnt;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) low_cnt <= 0;
        else if (CTRL_PIN) low_cnt <= 0;
        else if (low_cnt < 1000) low_cnt <= low_cnt + 1;
    end
    a_heat_pumps_off: assert property (OVER_TEMP |=>
        !FLASH_PUMP_EN && !BACKLIGHT_PUMP_EN) else $error("pump on hot");
    a_cool_flash_on: assert property (!OVER_TEMP[*2] |-> FLASH_PUMP_EN)
        else $error("flash pump off while cool");
    a_off_levels_one: assert property (SHUTDOWN |-> MAIN_LEVEL == 4'h1
        && SUB_LEVEL == 4'h1 && LOW_CURRENT_LEVEL == 4'h1
        && SCALE_SEL == SEL_20MA)
        else $error("register not one in shutdown");
    a_off_no_pump: assert property (SHUTDOWN[*2] |-> !BACKLIGHT_PUMP_EN)
        else $error("backlight pump on in shutdown");
    a_low_holds: assert property (!CTRL_PIN[*2] |->
        $stable(MAIN_LEVEL) || SHUTDOWN) else $error("level moved, pin low");
    a_edge_no_latch: assert property ($rose(CTRL_PIN) |=>
        $stable({MAIN_LEVEL, LOW_CURRENT_LEVEL, SCALE_SEL})[*8])
        else $error("latch inside burst");
    a_long_low_off: assert property (low_cnt == SHUTDOWN_COUNT + 4
        |-> SHUTDOWN) else $error("no shutdown after long low");
    a_short_low_on: assert property (
        !SHUTDOWN && low_cnt < SHUTDOWN_COUNT - 5 |=> !SHUTDOWN)
        else $error("early shutdown");
endmodule : pcw_props
bind pulse_count_current_scale_ctrl_test pcw_props #(
    .SHUTDOWN_COUNT(SIM_SHUTDOWN_COUNT)
) u_props (.CLK(clk), .RST(rst), .CTRL_PIN(pin), .OVER_TEMP(over_temp),
    .MAIN_LEVEL(main_l), .SUB_LEVEL(sub_l),
    .LOW_CURRENT_LEVEL(low_l), .SCALE_SEL(sel),
    .SHUTDOWN(shut), .BACKLIGHT_PUMP_EN(bl_en),
    .FLASH_PUMP_EN(fl_en));
`default_nettype wire

// ==== verif/pulse_count_current_scale_ctrl_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module pulse_count_current_scale_ctrl_test
    import pcw_pkg::*;
;
    localparam int SIM_SHUTDOWN_COUNT = 50;
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    logic          over_temp = 1'b0;
    wire logic     pin;
    logic [3:0]    main_l, sub_l, low_l;
    scale_sel_type sel;
    logic          shut, bl_en, fl_en;
    int            n_errors = 0;
    int            check_count = 0;
    scale_sel_type exp_sel [3] = '{SEL_20MA, SEL_30MA, SEL_15MA};
    initial forever #10 clk = ~clk;
    pcw_host_model u_host (.CLK(clk), .PIN(pin));
    pulse_count_current_scale_ctrl #(
        .SHUTDOWN_COUNT(SIM_SHUTDOWN_COUNT)
    ) u_dut (
        .CLK(clk), .RST(rst), .CTRL_PIN(pin), .OVER_TEMP(over_temp),
        .MAIN_LEVEL(main_l), .SUB_LEVEL(sub_l), .LOW_CURRENT_LEVEL(low_l),
        .SCALE_SEL(sel), .SHUTDOWN(shut), .BACKLIGHT_PUMP_EN(bl_en),
        .FLASH_PUMP_EN(fl_en));
    task chk(input logic [3:0] exp, input logic [3:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task results;
        if (n_errors == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        chk(4'h1, main_l);
        u_host.burst(17);
        u_host.burst(5);
        chk(4'h5, main_l);
        chk(4'h5, sub_l);
        chk(4'(SEL_20MA), 4'(sel));
        u_host.burst(20);
        for (int i = 0; i < 3; i++) begin
            u_host.burst(i + 1);
            chk(4'(exp_sel[i]), 4'(sel));
            chk(4'h5, main_l);
        end
        u_host.burst(4);
        chk(4'(SEL_LOW), 4'(sel));
        u_host.burst(21);
        u_host.burst(16);
        chk(4'h0, low_l);
        u_host.burst(22);
        u_host.burst(3);
        chk(4'h3, low_l);
        chk(4'h5, main_l);
        over_temp = 1'b1;
        repeat (3) @(negedge clk);
        chk(4'h0, 4'(fl_en));
        chk(4'h0, 4'(bl_en));
        over_temp = 1'b0;
        repeat (3) @(negedge clk);
        chk(4'h1, 4'(fl_en));
        chk(4'h1, 4'(bl_en));
        u_host.hold_low(60);
        chk(4'h1, 4'(shut));
        chk(4'h1, low_l);
        chk(4'h1, main_l);
        chk(4'h1, sub_l);
        chk(4'(SEL_20MA), 4'(sel));
        chk(4'h0, 4'(bl_en));
        u_host.burst(7);
        chk(4'h7, main_l);
        chk(4'h7, sub_l);
        chk(4'h0, 4'(shut));
        u_host.burst(18);
        u_host.burst(9);
        chk(4'h9, main_l);
        chk(4'h7, sub_l);
        u_host.burst(19);
        u_host.burst(2);
        chk(4'h2, sub_l);
        chk(4'h9, main_l);
        results();
    end
    // Whole sequence needs about 920 cycles
    initial begin
        #200us;
        n_errors++;
        results();
    end
endmodule : pulse_count_current_scale_ctrl_test
`default_nettype wire

// ==== verilog/pcw_pkg.sv ====
package pcw_pkg;

    // Edge counts that select a register (address codes)
    localparam logic [4:0] ADDR_EDGES_BASE  = 5'h11;  // 17 edges = address 1
    localparam logic [2:0] ADDR_SHARED      = 3'h1;
    localparam logic [2:0] ADDR_MAIN        = 3'h2;
    localparam logic [2:0] ADDR_SUB         = 3'h3;
    localparam logic [2:0] ADDR_MAX_CURRENT = 3'h4;   // max_current_scale
    localparam logic [2:0] ADDR_LOW_CURRENT = 3'h5;
    localparam logic [4:0] DATA_MAX_EDGES   = 5'h10;  // 16
    localparam logic [4:0] ADDR_MAX_EDGES   = 5'h15;  // 21

    // Register contents after reset / shutdown
    localparam logic [3:0] REG_RESET_VALUE  = 4'h1;
    localparam logic [2:0] ADDR_RESET_VALUE = 3'h1;

    // Scale codes held in max_current_scale
    localparam logic [3:0] SCALE_20MA = 4'h1;
    localparam logic [3:0] SCALE_30MA = 4'h2;
    localparam logic [3:0] SCALE_15MA = 4'h3;
    localparam logic [3:0] SCALE_LOW  = 4'h4;

    // Timing at a 50 MHz clock
    localparam int CLK_PERIOD_NS      = 20;
    localparam int LATCH_TIMEOUT_NS   = 500;
    localparam int SHUTDOWN_TIMEOUT_NS = 500000;
    localparam int LATCH_CYCLES =
        (LATCH_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHUTDOWN_CYCLES =
        (SHUTDOWN_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Output scale selection
    typedef enum logic [1:0] {
        SEL_20MA,
        SEL_30MA,
        SEL_15MA,
        SEL_LOW
    } scale_sel_type;

endpackage : pcw_pkg

// ==== verilog/pcw_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Saturating level-duration counter; flags when the level outlasts LIMIT
module pcw_timer
    import pcw_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int LIMIT = 25
) (
    // Clock and reset
    input  wire logic CLK,
    input  wire logic RST,
    // Level watch
    input  wire logic CLEAR,
    output logic      EXPIRED
);

    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             expired;
    } state_type;

    state_type state_reg;
    state_type state_next;

    always_comb begin
        state_next = state_reg;
        if (CLEAR) begin
            state_next.count   = '0;
            state_next.expired = 1'b0;
        end else if (state_reg.count < WIDTH'(LIMIT)) begin
            state_next.count = state_reg.count + WIDTH'(1);
        end else begin
            state_next.expired = 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign EXPIRED = state_reg.expired;

endmodule : pcw_timer
`default_nettype wire

// ==== verilog/pulse_count_current_scale_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module pulse_count_current_scale_ctrl
    import pcw_pkg::*;
#(
    parameter int SHUTDOWN_COUNT = SHUTDOWN_CYCLES
) (
    // Clock and reset
    input  wire logic      CLK,
    input  wire logic      RST,
    // Single-wire control pin
    input  wire logic      CTRL_PIN,
    // Thermal indication
    input  wire logic      OVER_TEMP,
    // Current sink settings, shutdown flag and pump enables
    output logic [3:0]     MAIN_LEVEL,
    output logic [3:0]     SUB_LEVEL,
    output logic [3:0]     LOW_CURRENT_LEVEL,
    output scale_sel_type  SCALE_SEL,
    output logic           SHUTDOWN,
    output logic           BACKLIGHT_PUMP_EN,
    output logic           FLASH_PUMP_EN
);

    typedef struct packed {
        logic       pin_prev;
        logic [4:0] edge_count;
        logic       pending;
        logic [2:0] address;
        logic [3:0] main_level;
        logic [3:0] sub_level;
        logic [3:0] max_current_scale;
        logic [3:0] low_current;
        logic       shutdown;
    } state_type;

    state_type state_reg;
    state_type state_next;

    localparam int FIRST_ADDR = int'(ADDR_SHARED);
    localparam int LAST_ADDR  = int'(ADDR_LOW_CURRENT);

    logic                        latch_expired;
    logic                        off_expired;
    logic                        rise;
    logic                        latch_now;
    logic                        count_is_data;
    logic                        count_is_addr;
    logic                        main_write;
    logic                        sub_write;
    logic                        scale_write;
    logic                        low_write;
    logic [3:0]                  data_value;
    logic [2:0]                  addr_value;
    logic [LAST_ADDR:FIRST_ADDR] addr_hit;
    scale_sel_type               scale_next;

    assign rise = CTRL_PIN & ~state_reg.pin_prev;

    // A new edge always wins over a latch due in the same cycle
    assign latch_now     = state_reg.pending & latch_expired & ~rise;
    assign count_is_data = state_reg.edge_count <= DATA_MAX_EDGES;
    assign count_is_addr = ~count_is_data
                         & (state_reg.edge_count <= ADDR_MAX_EDGES);

    // Code 16 reads back as 0 in four bits
    assign data_value = state_reg.edge_count[3:0];
    assign addr_value = 3'(state_reg.edge_count - ADDR_EDGES_BASE) + 3'h1;

    // One-hot view of the addressed register
    for (genvar i = FIRST_ADDR; i <= LAST_ADDR; i++) begin : g_addr_hit
        assign addr_hit[i] = state_reg.address == 3'(i);
    end

    // Address 1 loads both sink groups, 2 and 3 load one each
    assign main_write  = addr_hit[ADDR_SHARED] | addr_hit[ADDR_MAIN];
    assign sub_write   = addr_hit[ADDR_SHARED] | addr_hit[ADDR_SUB];
    assign scale_write = addr_hit[ADDR_MAX_CURRENT];
    assign low_write   = addr_hit[ADDR_LOW_CURRENT];

    // High-level timer restarts on each rising edge and while low
    pcw_timer #(
        .WIDTH (8),
        .LIMIT (LATCH_CYCLES)
    ) latch_timer (
        .CLK     (CLK),
        .RST     (RST),
        .CLEAR   (~CTRL_PIN | rise),
        .EXPIRED (latch_expired)
    );

    // Low-level timer for shutdown
    pcw_timer #(
        .WIDTH (16),
        .LIMIT (SHUTDOWN_COUNT)
    ) off_timer (
        .CLK     (CLK),
        .RST     (RST),
        .CLEAR   (CTRL_PIN),
        .EXPIRED (off_expired)
    );

    always_comb begin
        state_next          = state_reg;
        state_next.pin_prev = CTRL_PIN;
        if (off_expired) begin
            // Shutdown: every register back to 1, address 1
            state_next.shutdown          = 1'b1;
            state_next.address           = ADDR_RESET_VALUE;
            state_next.main_level        = REG_RESET_VALUE;
            state_next.sub_level         = REG_RESET_VALUE;
            state_next.max_current_scale = REG_RESET_VALUE;
            state_next.low_current       = REG_RESET_VALUE;
            state_next.edge_count        = '0;
            state_next.pending           = 1'b0;
            // The edge that ends a long low spell opens a burst
            if (rise) begin
                state_next.shutdown   = 1'b0;
                state_next.edge_count = 5'h01;
                state_next.pending    = 1'b1;
            end
        end else if (rise) begin
            state_next.shutdown = 1'b0;
            state_next.pending  = 1'b1;
            // Saturate so long bursts still read as out of range
            if (state_reg.edge_count != 5'h1f) begin
                state_next.edge_count = state_reg.edge_count + 5'h01;
            end
        end else if (latch_now) begin
            state_next.pending    = 1'b0;
            state_next.edge_count = '0;
            if (count_is_data) begin
                if (main_write) begin
                    state_next.main_level = data_value;
                end
                if (sub_write) begin
                    state_next.sub_level = data_value;
                end
                if (scale_write) begin
                    state_next.max_current_scale = data_value;
                end
                if (low_write) begin
                    state_next.low_current = data_value;
                end
            end else if (count_is_addr) begin
                state_next.address = addr_value;
            end
            // Counts above 21 leave address and data alone
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_reg                   <= '0;
            // Pin idles high; a low start value would fake an edge
            state_reg.pin_prev          <= 1'b1;
            state_reg.address           <= ADDR_RESET_VALUE;
            state_reg.main_level        <= REG_RESET_VALUE;
            state_reg.sub_level         <= REG_RESET_VALUE;
            state_reg.max_current_scale <= REG_RESET_VALUE;
            state_reg.low_current       <= REG_RESET_VALUE;
            state_reg.shutdown          <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // Undefined scale codes fall back to the 20mA table
    always_comb begin
        case (state_next.max_current_scale)
            SCALE_30MA: scale_next = SEL_30MA;
            SCALE_15MA: scale_next = SEL_15MA;
            SCALE_LOW:  scale_next = SEL_LOW;
            default:    scale_next = SEL_20MA;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            MAIN_LEVEL        <= REG_RESET_VALUE;
            SUB_LEVEL         <= REG_RESET_VALUE;
            LOW_CURRENT_LEVEL <= REG_RESET_VALUE;
            SCALE_SEL         <= SEL_20MA;
            SHUTDOWN          <= 1'b1;
        end else begin
            // Level codes persist across scale changes
            MAIN_LEVEL        <= state_next.main_level;
            SUB_LEVEL         <= state_next.sub_level;
            LOW_CURRENT_LEVEL <= state_next.low_current;
            SCALE_SEL         <= scale_next;
            SHUTDOWN          <= state_next.shutdown;
        end
    end

    // Pumps follow the thermal flag one cycle later
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            BACKLIGHT_PUMP_EN <= 1'b0;
            FLASH_PUMP_EN     <= 1'b0;
        end else begin
            BACKLIGHT_PUMP_EN <= ~state_next.shutdown & ~OVER_TEMP;
            FLASH_PUMP_EN     <= ~OVER_TEMP;
        end
    end

endmodule : pulse_count_current_scale_ctrl
`default_nettype wire
